// *** logic/line_event_interrupt_status.sv ***
// Pending flags, masks, tone key status and interrupt request for the line interface.
// Assumes event inputs synchronous to pclk; APB master per AMBA APB protocol.
// Function
// - Six alarm pending flags in line pending bits 7..2, alarm six at bit 7.
// - Hook change pending, bit 1, set on every hook state change after the first cycle out of reset, closure or opening.
// - Ring trip pending, bit 0, set on a ring trip event.
// - Writing one clears that pending bit only; other bits stay.
// - Calibration error pending, misc bit 2, hook change during calibration.
// - Indirect done pending, misc bit 1, set when pending indirect service finishes.
// - Tone key pending, misc bit 0, set when a key is detected.
// - Timer mask: eight timer event enables, one enables, zero masks.
// - Line mask mirrors line pending layout; one enables, zero masks.
// - Misc mask bits 2..0 enable misc events; bits 7..3 read zero.
// - Key status bit 4 high while a key is being detected; bits 7..5 zero.
// - Key code bits 3..0: digits 1..9 as binary, zero 1010, star 1011, pound 1100.
// - Letter keys: A 1101, C 1111, D 0000.
// - Timer events set timer pending flags at the same bits, cleared by writing one.
`timescale 1ns/1ps

module line_event_interrupt_status
  import line_event_pkg::*;
(
  input  wire logic                             pclk,
  input  wire logic                             presetn,
  input  wire logic                             psel,
  input  wire logic                             penable,
  input  wire logic                             pwrite,
  input  wire logic [line_event_pkg::ADDR_W-1:0] paddr,
  input  wire logic [line_event_pkg::DATA_W-1:0] pwdata,
  input  wire logic [3:0]                       pstrb,
  output logic      [line_event_pkg::DATA_W-1:0] prdata,
  output logic                                  pready,
  output logic                                  pslverr,
  input  wire logic [line_event_pkg::REG_W-1:0]  timer_event,
  input  wire logic [line_event_pkg::ALARM_N-1:0] alarm_event,
  input  wire logic                             ring_trip_event,
  input  wire logic                             hook_state,
  input  wire logic                             cal_running,
  input  wire logic                             indirect_busy,
  input  wire logic                             key_detect,
  input  wire logic [line_event_pkg::KEY_CODE_W-1:0] key_index,
  output logic                                  irq
);
  import line_event_pkg::*;

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------
  // Byte address of a register index
  function automatic logic [ADDR_W-1:0] reg_addr(input logic [IDX_W-1:0] idx);
    reg_addr = {idx, WORD_PAD};
  endfunction

  // Key index to reported code
  function automatic logic [KEY_CODE_W-1:0] encode_key(input logic [KEY_CODE_W-1:0] idx);
    case (idx)
      KEY_IDX_ZERO:  encode_key = KEY_CODE_ZERO;
      KEY_IDX_STAR:  encode_key = KEY_CODE_STAR;
      KEY_IDX_POUND: encode_key = KEY_CODE_POUND;
      KEY_IDX_A:     encode_key = KEY_CODE_A;
      KEY_IDX_B:     encode_key = KEY_CODE_B;
      KEY_IDX_C:     encode_key = KEY_CODE_C;
      KEY_IDX_D:     encode_key = KEY_CODE_D;
      default:       encode_key = idx;
    endcase
  endfunction

  // Write-one-clear with the new event taking priority
  function automatic logic [REG_W-1:0] w1c_next(input logic [REG_W-1:0] cur,
                                                input logic [REG_W-1:0] clr,
                                                input logic [REG_W-1:0] set);
    w1c_next = (cur & ~clr) | set;
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  bus_state_t                bus_q;
  logic [REG_W-1:0]          timer_pend_q;
  logic [REG_W-1:0]          line_pend_q;
  logic [REG_W-1:0]          misc_pend_q;
  logic [REG_W-1:0]          timer_mask_q;
  logic [REG_W-1:0]          line_mask_q;
  logic [REG_W-1:0]          misc_mask_q;
  logic                      key_present_q;
  logic [KEY_CODE_W-1:0]     key_code_q;
  logic                      hook_prev_q;
  logic                      hook_armed_q;
  logic                      busy_prev_q;
  logic                      key_prev_q;
  logic [DATA_W-1:0]         prdata_q;
  logic                      pready_q;
  logic                      pslverr_q;
  logic                      irq_q;

  logic                      access_done;
  logic                      wr_en;
  logic                      hit_timer_pend;
  logic                      hit_line_pend;
  logic                      hit_misc_pend;
  logic                      hit_timer_mask;
  logic                      hit_line_mask;
  logic                      hit_misc_mask;
  logic                      hit_key_status;
  logic                      mapped;
  logic [REG_W-1:0]          wbyte;
  logic [REG_W-1:0]          timer_clr;
  logic [REG_W-1:0]          line_clr;
  logic [REG_W-1:0]          misc_clr;
  logic                      hook_edge;
  logic                      cal_err_event;
  logic                      ind_done_event;
  logic                      key_rise;
  logic [REG_W-1:0]          line_set;
  logic [REG_W-1:0]          misc_set;
  logic [REG_W-1:0]          key_status;
  logic [REG_W-1:0]          rd_byte;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  // A transfer completes at the edge where pready is seen high
  assign access_done    = psel & penable & pready_q;
  assign wr_en          = access_done & pwrite & pstrb[0];
  assign wbyte          = pwdata[REG_W-1:0];
  assign hit_timer_pend = (paddr == reg_addr(IDX_TIMER_PEND));
  assign hit_line_pend  = (paddr == reg_addr(IDX_LINE_PEND));
  assign hit_misc_pend  = (paddr == reg_addr(IDX_MISC_PEND));
  assign hit_timer_mask = (paddr == reg_addr(IDX_TIMER_MASK));
  assign hit_line_mask  = (paddr == reg_addr(IDX_LINE_MASK));
  assign hit_misc_mask  = (paddr == reg_addr(IDX_MISC_MASK));
  assign hit_key_status = (paddr == reg_addr(IDX_KEY_STATUS));
  assign mapped         = hit_timer_pend | hit_line_pend | hit_misc_pend | hit_timer_mask
                        | hit_line_mask | hit_misc_mask | hit_key_status;

  // Clear masks from a write of ones
  assign timer_clr = (wr_en & hit_timer_pend) ? wbyte : PEND_RESET;
  assign line_clr  = (wr_en & hit_line_pend)  ? wbyte : PEND_RESET;
  assign misc_clr  = (wr_en & hit_misc_pend)  ? wbyte : PEND_RESET;

  // ----------------------------------------------------------------
  // Event detection
  // ----------------------------------------------------------------
  // Hook edge is ignored for the first cycle; the previous level is unknown until then
  assign hook_edge      = hook_armed_q & (hook_state ^ hook_prev_q);
  assign cal_err_event  = hook_edge & cal_running;
  assign ind_done_event = busy_prev_q & ~indirect_busy;
  assign key_rise       = key_detect & ~key_prev_q;

  // Event vectors in register layout
  assign line_set = {alarm_event, hook_edge, ring_trip_event};
  assign misc_set = {{(REG_W-MISC_USED){1'b0}}, cal_err_event, ind_done_event, key_rise};

  // Previous levels for edge detection
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      hook_prev_q  <= 1'b0;
      hook_armed_q <= 1'b0;
      busy_prev_q  <= 1'b0;
      key_prev_q   <= 1'b0;
    end
    else
    begin
      hook_prev_q  <= hook_state;
      hook_armed_q <= 1'b1;
      busy_prev_q  <= indirect_busy;
      key_prev_q   <= key_detect;
    end
  end

  // ----------------------------------------------------------------
  // Pending flags
  // ----------------------------------------------------------------
  // Flags set even while masked, so software can poll them
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      timer_pend_q <= PEND_RESET;
      line_pend_q  <= PEND_RESET;
      misc_pend_q  <= PEND_RESET;
    end
    else
    begin
      timer_pend_q <= w1c_next(timer_pend_q, timer_clr, timer_event);
      line_pend_q  <= w1c_next(line_pend_q, line_clr, line_set);
      misc_pend_q  <= w1c_next(misc_pend_q, misc_clr, misc_set);
    end
  end

  // ----------------------------------------------------------------
  // Masks
  // ----------------------------------------------------------------
  // Reserved misc mask bits are never stored, so they read zero
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      timer_mask_q <= MASK_RESET;
      line_mask_q  <= MASK_RESET;
      misc_mask_q  <= MASK_RESET;
    end
    else
    begin
      if (wr_en && hit_timer_mask)
        timer_mask_q <= wbyte;
      if (wr_en && hit_line_mask)
        line_mask_q <= wbyte;
      if (wr_en && hit_misc_mask)
        misc_mask_q <= {{(REG_W-MISC_USED){1'b0}}, wbyte[MISC_USED-1:0]};
    end
  end

  // ----------------------------------------------------------------
  // Tone key status
  // ----------------------------------------------------------------
  // Code holds the last key after detection ends, so a late read still sees it
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      key_present_q <= 1'b0;
      key_code_q    <= CODE_RESET;
    end
    else
    begin
      key_present_q <= key_detect;
      if (key_detect)
        key_code_q <= encode_key(key_index);
    end
  end

  assign key_status = {{(REG_W-KEY_PRESENT_BIT-1){1'b0}}, key_present_q, key_code_q};

  // ----------------------------------------------------------------
  // Interrupt request
  // ----------------------------------------------------------------
  // Registered, so it trails the pending flags by one cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq_q <= 1'b0;
    else
    begin
      irq_q <= |((timer_pend_q & timer_mask_q) | (line_pend_q & line_mask_q)
                 | (misc_pend_q & misc_mask_q));
    end
  end

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  // Read mux
  always_comb
  begin
    rd_byte = PEND_RESET;
    if (hit_timer_pend)
      rd_byte = timer_pend_q;
    else if (hit_line_pend)
      rd_byte = line_pend_q;
    else if (hit_misc_pend)
      rd_byte = misc_pend_q;
    else if (hit_timer_mask)
      rd_byte = timer_mask_q;
    else if (hit_line_mask)
      rd_byte = line_mask_q;
    else if (hit_misc_mask)
      rd_byte = misc_mask_q;
    else if (hit_key_status)
      rd_byte = key_status;
  end

  // One wait state: data and response are registered at the same edge that raises pready
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      bus_q     <= BUS_WAIT;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= RDATA_ZERO;
    end
    else
    begin
      case (bus_q)
        BUS_WAIT:
        begin
          if (psel && penable)
          begin
            bus_q     <= BUS_READY;
            pready_q  <= 1'b1;
            pslverr_q <= ~mapped;
            prdata_q  <= (pwrite || !mapped) ? RDATA_ZERO : {{(DATA_W-REG_W){1'b0}}, rd_byte};
          end
        end
        BUS_READY:
        begin
          bus_q     <= BUS_WAIT;
          pready_q  <= 1'b0;
          pslverr_q <= 1'b0;
          prdata_q  <= RDATA_ZERO;
        end
        default: bus_q <= BUS_WAIT;
      endcase
    end
  end

  assign prdata  = prdata_q;
  assign pready  = pready_q;
  assign pslverr = pslverr_q;
  assign irq     = irq_q;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // A clearing write to the line flags; a key held over two edges
  sequence s_line_wr; wr_en && hit_line_pend; endsequence
  sequence s_key_held; key_detect ##1 key_detect; endsequence
  // Flags and masks are registered, so each is checked one cycle after its cause
  property p_alarm_set; (alarm_event != '0) |=>
    ((line_pend_q[ALARM_MSB:ALARM_LSB] & $past(alarm_event)) == $past(alarm_event)); endproperty
  a_alarm_set: assert property (p_alarm_set) else $error("alarm flag not set");
  property p_hook_set; (hook_armed_q && (hook_state != hook_prev_q)) |=> line_pend_q[HOOK_BIT]; endproperty
  a_hook_set: assert property (p_hook_set) else $error("hook change flag not set");
  property p_ring_set; ring_trip_event |=> line_pend_q[RING_TRIP_BIT]; endproperty
  a_ring_set: assert property (p_ring_set) else $error("ring trip flag not set");
  property p_w1c; (s_line_wr and (line_set == '0)) |=>
    (line_pend_q == ($past(line_pend_q) & ~$past(wbyte))); endproperty
  a_w1c: assert property (p_w1c) else $error("write one clear wrong");
  property p_cal_err; (hook_edge && cal_running) |=> misc_pend_q[CAL_ERR_BIT]; endproperty
  a_cal_err: assert property (p_cal_err) else $error("calibration error flag not set");
  property p_ind_done; $fell(indirect_busy) |=> misc_pend_q[IND_DONE_BIT]; endproperty
  a_ind_done: assert property (p_ind_done) else $error("indirect done flag not set");
  property p_tone_set; $rose(key_detect) |=> misc_pend_q[TONE_KEY_BIT]; endproperty
  a_tone_set: assert property (p_tone_set) else $error("tone key flag not set");
  property p_timer_mask_wr; (wr_en && hit_timer_mask) |=> (timer_mask_q == $past(wbyte)); endproperty
  a_timer_mask_wr: assert property (p_timer_mask_wr) else $error("timer mask not written");
  property p_line_mask_wr; (wr_en && hit_line_mask) |=> (line_mask_q == $past(wbyte)); endproperty
  a_line_mask_wr: assert property (p_line_mask_wr) else $error("line mask not written");
  property p_misc_reserved; (wr_en && hit_misc_mask) |=>
    (misc_mask_q == ($past(wbyte) & {{(REG_W-MISC_USED){1'b0}}, {MISC_USED{1'b1}}})); endproperty
  a_misc_reserved: assert property (p_misc_reserved) else $error("misc mask write wrong");
  property p_key_present; s_key_held |->
    (key_status[KEY_PRESENT_BIT] && (key_status[REG_W-1:KEY_PRESENT_BIT+1] == '0)); endproperty
  a_key_present: assert property (p_key_present) else $error("key present bit wrong");
  property p_key_zero; (key_detect && key_index == KEY_IDX_ZERO) |=> (key_code_q == KEY_CODE_ZERO); endproperty
  a_key_zero: assert property (p_key_zero) else $error("digit zero code wrong");
  property p_key_letter; (key_detect && key_index == KEY_IDX_D) |=> (key_code_q == KEY_CODE_D); endproperty
  a_key_letter: assert property (p_key_letter) else $error("letter D code wrong");
  property p_timer_set; (timer_event != '0) |=>
    ((timer_pend_q & $past(timer_event)) == $past(timer_event)); endproperty
  a_timer_set: assert property (p_timer_set) else $error("timer flag not set");
  property p_irq; (|((line_pend_q & line_mask_q) | (misc_pend_q & misc_mask_q) | (timer_pend_q & timer_mask_q)))
    |=> irq_q; endproperty
  a_irq: assert property (p_irq) else $error("interrupt not raised");
  property p_set_wins; (s_line_wr and ring_trip_event) |=> line_pend_q[RING_TRIP_BIT]; endproperty
  a_set_wins: assert property (p_set_wins) else $error("event lost to clear");

endmodule // line_event_interrupt_status

// *** logic/line_event_pkg.sv ***
// Register map, field positions, reset values and key codes of the line event interrupt block.
// Assumes a 32-bit APB slave where each 8-bit register sits in the low byte of one aligned word.
package line_event_pkg;

  // ----------------------------------------------------------------
  // Bus geometry
  // ----------------------------------------------------------------
  localparam int          DATA_W    = 32;
  localparam int          ADDR_W    = 8;
  localparam int          REG_W     = 8;
  localparam int          IDX_W     = 6;
  localparam logic [1:0]  WORD_PAD  = 2'h0;

  // ----------------------------------------------------------------
  // Register indices; byte address is four times the index
  // ----------------------------------------------------------------
  localparam logic [IDX_W-1:0] IDX_TIMER_PEND = 6'h12;
  localparam logic [IDX_W-1:0] IDX_LINE_PEND  = 6'h13;
  localparam logic [IDX_W-1:0] IDX_MISC_PEND  = 6'h14;
  localparam logic [IDX_W-1:0] IDX_TIMER_MASK = 6'h15;
  localparam logic [IDX_W-1:0] IDX_LINE_MASK  = 6'h16;
  localparam logic [IDX_W-1:0] IDX_MISC_MASK  = 6'h17;
  localparam logic [IDX_W-1:0] IDX_KEY_STATUS = 6'h18;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int ALARM_MSB       = 7;
  localparam int ALARM_LSB       = 2;
  localparam int ALARM_N         = 6;
  localparam int HOOK_BIT        = 1;
  localparam int RING_TRIP_BIT   = 0;
  localparam int CAL_ERR_BIT     = 2;
  localparam int IND_DONE_BIT    = 1;
  localparam int TONE_KEY_BIT    = 0;
  localparam int MISC_USED       = 3;
  localparam int KEY_PRESENT_BIT = 4;
  localparam int KEY_CODE_W      = 4;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [REG_W-1:0]      PEND_RESET = 8'h00;
  localparam logic [REG_W-1:0]      MASK_RESET = 8'h00;
  localparam logic [KEY_CODE_W-1:0] CODE_RESET = 4'h0;
  localparam logic [DATA_W-1:0]     RDATA_ZERO = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Key index at the detector input (0..9 digits, then * # A B C D)
  // ----------------------------------------------------------------
  localparam logic [KEY_CODE_W-1:0] KEY_IDX_ZERO  = 4'h0;
  localparam logic [KEY_CODE_W-1:0] KEY_IDX_STAR  = 4'hA;
  localparam logic [KEY_CODE_W-1:0] KEY_IDX_POUND = 4'hB;
  localparam logic [KEY_CODE_W-1:0] KEY_IDX_A     = 4'hC;
  localparam logic [KEY_CODE_W-1:0] KEY_IDX_B     = 4'hD;
  localparam logic [KEY_CODE_W-1:0] KEY_IDX_C     = 4'hE;
  localparam logic [KEY_CODE_W-1:0] KEY_IDX_D     = 4'hF;

  // ----------------------------------------------------------------
  // Reported key codes
  // ----------------------------------------------------------------
  localparam logic [KEY_CODE_W-1:0] KEY_CODE_ZERO  = 4'hA;
  localparam logic [KEY_CODE_W-1:0] KEY_CODE_STAR  = 4'hB;
  localparam logic [KEY_CODE_W-1:0] KEY_CODE_POUND = 4'hC;
  localparam logic [KEY_CODE_W-1:0] KEY_CODE_A     = 4'hD;
  localparam logic [KEY_CODE_W-1:0] KEY_CODE_B     = 4'hE;
  localparam logic [KEY_CODE_W-1:0] KEY_CODE_C     = 4'hF;
  localparam logic [KEY_CODE_W-1:0] KEY_CODE_D     = 4'h0;

  // ----------------------------------------------------------------
  // Bus slave phase
  // ----------------------------------------------------------------
  typedef enum logic [0:0] {
    BUS_WAIT  = 1'b0,
    BUS_READY = 1'b1
  } bus_state_t;

endpackage

// *** bench/tb.sv ***
// Self-checking bench for the line event interrupt block: APB master, event stimulus, read-data monitor.
// Assumes the design package and one 200 MHz clock; assertions live inside the design files.
`timescale 1ns/1ps

module tb;
  import line_event_pkg::*;

  // ----------------------------------------------------------------
  // Addresses, signals and bench state
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] A_TP  = {IDX_TIMER_PEND, WORD_PAD};
  localparam logic [ADDR_W-1:0] A_LP  = {IDX_LINE_PEND, WORD_PAD};
  localparam logic [ADDR_W-1:0] A_MP  = {IDX_MISC_PEND, WORD_PAD};
  localparam logic [ADDR_W-1:0] A_TM  = {IDX_TIMER_MASK, WORD_PAD};
  localparam logic [ADDR_W-1:0] A_LM  = {IDX_LINE_MASK, WORD_PAD};
  localparam logic [ADDR_W-1:0] A_MM  = {IDX_MISC_MASK, WORD_PAD};
  localparam logic [ADDR_W-1:0] A_KS  = {IDX_KEY_STATUS, WORD_PAD};
  localparam logic [ADDR_W-1:0] A_BAD = 8'h64;
  logic              pclk, presetn, psel, penable, pwrite, pslverr, pready, irq;
  logic [ADDR_W-1:0] paddr;
  logic [31:0]       pwdata, prdata, seed;
  logic [3:0]        pstrb, key_index;
  logic [7:0]        timer_event;
  logic [5:0]        alarm_event;
  logic              ring_trip_event, hook_state, cal_running, indirect_busy, key_detect;
  logic [32:0]       exp_q[$];
  int                fails;
  int                num_checks;

  line_event_interrupt_status DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .timer_event(timer_event), .alarm_event(alarm_event),
    .ring_trip_event(ring_trip_event), .hook_state(hook_state), .cal_running(cal_running),
    .indirect_busy(indirect_busy), .key_detect(key_detect), .key_index(key_index), .irq(irq));

  // Free-running 5 ns clock
  initial
  begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // Expected key code from the detector index; the letter B code is a design choice
  function automatic logic [3:0] code_of(input logic [3:0] i);
    if (i == 4'h0) return 4'hA;
    if (i <= 4'h9) return i;
    return i + 4'h1;
  endfunction

  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict();
    $display("checks=%0d mismatches=%0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // One APB transfer; ev holds a ring trip event up to and including the completion edge
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                      input logic ev, input logic [32:0] exp);
    int n;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d; pstrb <= s;
    if (ev) ring_trip_event <= 1'b1;
    if (!wr) exp_q.push_back(exp);
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (n >= 20)
    begin
      fails++;
      print_verdict();
    end
    psel <= 1'b0; penable <= 1'b0; ring_trip_event <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    xfer(1'b1, a, {24'h00_0000, d}, 4'hF, 1'b0, 33'h0_0000_0000);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] d, input logic e);
    xfer(1'b0, a, 32'h0000_0000, 4'hF, 1'b0, {e, 24'h00_0000, d});
  endtask

  // One-cycle event pulses; h toggles the hook level
  task automatic pulse(input logic [7:0] t, input logic [5:0] a, input logic r, input logic h);
    @(posedge pclk);
    timer_event <= t; alarm_event <= a; ring_trip_event <= r;
    if (h) hook_state <= ~hook_state;
    @(posedge pclk);
    timer_event <= 8'h00; alarm_event <= 6'h00; ring_trip_event <= 1'b0;
  endtask

  // Read monitor: each completed read is compared with the oldest note
  always @(posedge pclk)
    if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && pwrite === 1'b0)
    begin
      if (exp_q.size() == 0) fails++;
      else check({pslverr, prdata}, exp_q.pop_front());
    end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    logic [7:0] te, w, r;
    logic [5:0] ae;
    int i;
    seed = 32'h0000_D52F; fails = 0; num_checks = 0;
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00; pwdata = 32'h0000_0000;
    pstrb = 4'hF; timer_event = 8'h00; alarm_event = 6'h00; ring_trip_event = 1'b0; hook_state = 1'b0;
    cal_running = 1'b0; indirect_busy = 1'b0; key_detect = 1'b0; key_index = 4'h0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    // Reset values and an unmapped address
    for (i = 0; i < 7; i++) rd(A_TP + 8'(4 * i), 8'h00, 1'b0);
    rd(A_BAD, 8'h00, 1'b1);
    $display("test 1 done");
    // Mask read-back; reserved misc bits and key status writes are dropped
    r = 8'(rnd()); wr(A_TM, r); rd(A_TM, r, 1'b0);
    r = 8'(rnd()); wr(A_LM, r); rd(A_LM, r, 1'b0);
    r = 8'(rnd()); wr(A_MM, r); rd(A_MM, r & 8'h07, 1'b0);
    wr(A_KS, 8'hFF); rd(A_KS, 8'h00, 1'b0);
    wr(A_TM, 8'h00); wr(A_LM, 8'h00); wr(A_MM, 8'h00);
    $display("test 2 done");
    // Masked events still set flags and keep irq low
    te = 8'(rnd()); ae = 6'(rnd());
    pulse(te, ae, 1'b1, 1'b1);
    @(posedge pclk); indirect_busy <= 1'b1;
    @(posedge pclk); indirect_busy <= 1'b0;
    rd(A_TP, te, 1'b0);
    rd(A_LP, {ae, 2'b11}, 1'b0);
    rd(A_MP, 8'h02, 1'b0);
    check({32'h0000_0000, irq}, 33'h0_0000_0000);
    // Write-one-to-clear touches only the written bits
    w = 8'(rnd()); wr(A_LP, w); rd(A_LP, {ae, 2'b11} & ~w, 1'b0);
    wr(A_TP, 8'hFF); rd(A_TP, 8'h00, 1'b0);
    wr(A_LP, 8'hFF);
    $display("test 3 done");
    // Hook change during calibration
    @(posedge pclk); cal_running <= 1'b1;
    pulse(8'h00, 6'h00, 1'b0, 1'b1);
    @(posedge pclk); cal_running <= 1'b0;
    rd(A_MP, 8'h06, 1'b0);
    rd(A_LP, 8'h02, 1'b0);
    wr(A_MP, 8'hFF); wr(A_LP, 8'hFF);
    $display("test 4 done");
    // Enabled flag drives irq; event at the clearing edge wins; write with pstrb[0] low ignored
    wr(A_LM, 8'h01);
    pulse(8'h00, 6'h00, 1'b1, 1'b0);
    repeat (2) @(posedge pclk);
    check({32'h0000_0000, irq}, 33'h0_0000_0001);
    xfer(1'b1, A_LP, 32'h0000_0001, 4'hF, 1'b1, 33'h0_0000_0000);
    rd(A_LP, 8'h01, 1'b0);
    xfer(1'b1, A_LP, 32'h0000_0001, 4'hE, 1'b0, 33'h0_0000_0000);
    rd(A_LP, 8'h01, 1'b0);
    wr(A_LP, 8'h01);
    repeat (2) @(posedge pclk);
    check({32'h0000_0000, irq}, 33'h0_0000_0000);
    $display("test 5 done");
    // Every key index: live status, held code after release, pending flag
    for (i = 0; i < 16; i++)
    begin
      @(posedge pclk); key_index <= 4'(i); key_detect <= 1'b1;
      rd(A_KS, {4'h1, code_of(4'(i))}, 1'b0);
      @(posedge pclk); key_detect <= 1'b0;
      rd(A_KS, {4'h0, code_of(4'(i))}, 1'b0);
      rd(A_MP, 8'h01, 1'b0);
      wr(A_MP, 8'h01);
    end
    $display("test 6 done");
    print_verdict();
  end

endmodule // tb
